// ==== include/sram_core_params.svh ====
// constants of the synchronous burst sram core
// assumes one clock and the 128k x 36 organisation
`ifndef SRAM_CORE_PARAMS_SVH
`define SRAM_CORE_PARAMS_SVH

`define SRAM_UPPER_W      15
`define SRAM_BURST_W      2
`define SRAM_ADDR_W       17
`define SRAM_DEPTH        131072
`define SRAM_LANES        4
`define SRAM_LANE_W       9
`define SRAM_DATA_W       36
`define SRAM_WCMD_W       21
`define SRAM_FIFO_DEPTH   16
`define SRAM_SLEEP_CYCLES 2
`define SRAM_PIPE_STAGES  2

`endif

// ==== include/sram_core_pkg.sv ====
// types of the synchronous burst sram core
// assumes the constants header sits in the include path
`include "sram_core_params.svh"

package sram_core_pkg;

   typedef enum logic [1:0] {
      KIND_IDLE  = 2'b00,
      KIND_READ  = 2'b01,
      KIND_WRITE = 2'b10
   } op_kind_t;

   typedef logic [`SRAM_LANE_W-1:0] lane_t;

   typedef lane_t [`SRAM_LANES-1:0] data_word_t;

   typedef struct packed {
      logic [`SRAM_ADDR_W-1:0] addr;
      logic [`SRAM_LANES-1:0]  lane_en;
   } wcmd_t;

endpackage : sram_core_pkg

// ==== logic/sram_wcmd_fifo.sv ====
// fifo holding pending late-write commands
// assumes one clock and an asynchronous active high reset
`timescale 1ns/1ps
`default_nettype none

module sram_wcmd_fifo #(
   parameter int WIDTH = 21,
   parameter int DEPTH = 16
) (
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output wire logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output wire logic             out_valid,
   input  wire logic             out_ready,
   output wire logic [WIDTH-1:0] out_data
);

   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] store [DEPTH];
   logic [PW-1:0]    wr_ptr_reg;
   logic [PW-1:0]    rd_ptr_reg;
   logic [PW:0]      count_reg;
   logic             push;
   logic             pop;

   assign in_ready  = (count_reg != (PW+1)'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign out_data  = store[rd_ptr_reg];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge ref_clk) begin
      if (push) begin
         store[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end

endmodule : sram_wcmd_fifo

`default_nettype wire

// ==== logic/sync_burst_sram_core.sv ====
// synchronous burst sram core, 128k x 36, late write
// assumes inputs synchronous to ref_clk; data pin split in/out/enable
`timescale 1ns/1ps
`default_nettype none
`include "sram_core_params.svh"

module sync_burst_sram_core (
   input  wire logic                             ref_clk,
   input  wire logic                             rst,
   input  wire logic                             clock_gate_n,
   input  wire logic                             burst_step_or_load,
   input  wire logic                             write_strobe_n,
   input  wire logic                             chip_select_first_n,
   input  wire logic                             chip_select_second,
   input  wire logic                             chip_select_third_n,
   input  wire logic                             lane_a_strobe_n,
   input  wire logic                             lane_b_strobe_n,
   input  wire logic                             lane_c_strobe_n,
   input  wire logic                             lane_d_strobe_n,
   input  wire logic [`SRAM_UPPER_W-1:0]         addr_upper,
   input  wire logic [`SRAM_BURST_W-1:0]         burst_start_bits,
   input  wire logic                             output_drive_n,
   input  wire logic                             latency_select_n,
   input  wire logic                             sequential_order_n,
   input  wire logic                             sleep_request,
   input  wire sram_core_pkg::data_word_t        lane_io_in,
   output var  sram_core_pkg::data_word_t        lane_io_out,
   output wire logic                             lane_io_oe,
   output wire logic                             sleep_active
);

   // ****************************************************************
   // decode helpers
   // ****************************************************************

   function automatic logic [`SRAM_BURST_W-1:0] burst_low(
      input logic [`SRAM_BURST_W-1:0] start,
      input logic [`SRAM_BURST_W-1:0] step,
      input logic                     interleave
   );
      if (interleave) begin
         burst_low = start ^ step;
      end else begin
         burst_low = start + step;
      end
   endfunction : burst_low

   // ****************************************************************
   // declarations
   // ****************************************************************

   sram_core_pkg::data_word_t    mem [`SRAM_DEPTH];

   logic [`SRAM_SLEEP_CYCLES-1:0] sleep_sync_reg;
   sram_core_pkg::op_kind_t      kind_reg;
   sram_core_pkg::op_kind_t      kind_next;
   logic [`SRAM_UPPER_W-1:0]     base_reg;
   logic [`SRAM_BURST_W-1:0]     start_reg;
   logic [`SRAM_BURST_W-1:0]     cnt_reg;
   logic [`SRAM_BURST_W-1:0]     step_cnt;
   logic [`SRAM_ADDR_W-1:0]      eff_addr;
   logic [`SRAM_PIPE_STAGES-1:0] wp_reg;
   sram_core_pkg::data_word_t    rd_word;
   sram_core_pkg::data_word_t    rd1_reg;
   logic                         rd1_valid_reg;
   logic                         out_valid_reg;
   logic [`SRAM_LANES-1:0]       lane_en;
   logic                         run;
   logic                         selected;
   logic                         load;
   logic                         flow;
   logic                         read_start;
   logic                         read_go;
   logic                         write_start;
   logic                         write_go;
   logic                         wr_fire;
   logic                         fifo_in_ready;
   logic                         fifo_out_valid;
   sram_core_pkg::wcmd_t         push_cmd;
   sram_core_pkg::wcmd_t         pop_cmd;
   sram_core_pkg::data_word_t    fire_word;

   // ****************************************************************
   // sleep and clock gate
   // ****************************************************************

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sleep_sync_reg <= '0;
      end else begin
         sleep_sync_reg <= {sleep_sync_reg[`SRAM_SLEEP_CYCLES-2:0], sleep_request};
      end
   end

   assign sleep_active = sleep_sync_reg[`SRAM_SLEEP_CYCLES-1];

   assign run = !clock_gate_n && !sleep_active;

   // ****************************************************************
   // command decode
   // ****************************************************************

   assign selected = !chip_select_first_n && chip_select_second && !chip_select_third_n;
   assign load     = !burst_step_or_load;
   assign flow     = !latency_select_n;
   assign lane_en  = ~{lane_d_strobe_n, lane_c_strobe_n, lane_b_strobe_n, lane_a_strobe_n};

   assign read_start  = run && load && selected && write_strobe_n;
   assign write_start = run && load && selected && !write_strobe_n;
   assign read_go  = read_start || (run && !load && kind_reg == sram_core_pkg::KIND_READ);
   assign write_go = write_start || (run && !load && kind_reg == sram_core_pkg::KIND_WRITE);

   always_comb begin
      kind_next = kind_reg;
      if (load) begin
         if (!selected) begin
            kind_next = sram_core_pkg::KIND_IDLE;
         end else if (write_strobe_n) begin
            kind_next = sram_core_pkg::KIND_READ;
         end else begin
            kind_next = sram_core_pkg::KIND_WRITE;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         kind_reg <= sram_core_pkg::KIND_IDLE;
      end else if (run) begin
         kind_reg <= kind_next;
      end
   end

   // ****************************************************************
   // burst address counter
   // ****************************************************************

   assign step_cnt = cnt_reg + 2'h1;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         base_reg  <= '0;
         start_reg <= '0;
         cnt_reg   <= '0;
      end else if (run) begin
         if (load && selected) begin
            base_reg  <= addr_upper;
            start_reg <= burst_start_bits;
            cnt_reg   <= '0;
         end else if (!load && kind_reg != sram_core_pkg::KIND_IDLE) begin
            cnt_reg <= step_cnt;
         end
      end
   end

   always_comb begin
      if (load) begin
         eff_addr = {addr_upper, burst_start_bits};
      end else begin
         eff_addr = {base_reg, burst_low(start_reg, step_cnt, sequential_order_n)};
      end
   end

   // ****************************************************************
   // late write path
   // ****************************************************************

   assign push_cmd.addr    = eff_addr;
   assign push_cmd.lane_en = lane_en;

   sram_wcmd_fifo #(
      .WIDTH (`SRAM_WCMD_W),
      .DEPTH (`SRAM_FIFO_DEPTH)
   ) u_wcmd_fifo (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .in_valid  (write_go),
      .in_ready  (fifo_in_ready),
      .in_data   (push_cmd),
      .out_valid (fifo_out_valid),
      .out_ready (wr_fire),
      .out_data  (pop_cmd)
   );

   // stages counting edges since the write command
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wp_reg <= '0;
      end else if (run) begin
         wp_reg <= {wp_reg[0], write_go && fifo_in_ready};
      end
   end

   assign wr_fire = run && fifo_out_valid && (flow ? wp_reg[0] : wp_reg[1]);

   always_ff @(posedge ref_clk) begin
      if (wr_fire) begin
         for (int i = 0; i < `SRAM_LANES; i++) begin
            if (pop_cmd.lane_en[i]) begin
               mem[pop_cmd.addr][i] <= lane_io_in[i];
            end
         end
      end
   end

   // ****************************************************************
   // read path
   // ****************************************************************

   assign rd_word = mem[eff_addr];

   // word under the write being fired, watched by the checks
   assign fire_word = mem[pop_cmd.addr];

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rd1_reg       <= '0;
         rd1_valid_reg <= 1'b0;
         lane_io_out   <= '0;
         out_valid_reg <= 1'b0;
      end else if (run) begin
         rd1_valid_reg <= read_go;
         if (read_go) begin
            rd1_reg <= rd_word;
         end
         if (flow) begin
            out_valid_reg <= read_go;
            if (read_go) begin
               lane_io_out <= rd_word;
            end
         end else begin
            out_valid_reg <= rd1_valid_reg;
            if (rd1_valid_reg) begin
               lane_io_out <= rd1_reg;
            end
         end
      end
   end

   assign lane_io_oe = out_valid_reg && !output_drive_n && !sleep_active;

   // ****************************************************************
   // assertions
   // ****************************************************************

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   sequence s_pipe_read;
      !flow && read_start ##1 run;
   endsequence

   sequence s_pipe_write;
      !flow && write_start ##1 run ##1 run;
   endsequence

   sequence s_flow_write;
      flow && write_start ##1 run;
   endsequence

   AST_SELECT: assert property (run && load && !selected |=> !rd1_valid_reg)
      else $error("read started while deselected");

   AST_READ_START: assert property (read_start |=> rd1_valid_reg)
      else $error("read start not registered");

   AST_HOLD: assert property (!run |=> $stable(kind_reg) && $stable(cnt_reg)
                              && $stable(out_valid_reg) && $stable(wp_reg))
      else $error("state changed on an ignored edge");

   AST_PIPE_LAT: assert property (s_pipe_read |=> out_valid_reg)
      else $error("pipelined read data not valid after two edges");

   AST_FLOW_LAT: assert property (flow && read_start |=> out_valid_reg)
      else $error("flow-through read data not valid after one edge");

   AST_OE_ASYNC: assert property (output_drive_n |-> !lane_io_oe)
      else $error("data driven with output drive disabled");

   AST_NOP_WRITE: assert property (wr_fire && pop_cmd.lane_en == '0
                                   |=> mem[$past(pop_cmd.addr)] == $past(fire_word))
      else $error("empty write changed the addressed word");

   AST_PIPE_WRITE: assert property (s_pipe_write |-> wr_fire)
      else $error("pipelined write data not taken on third edge");

   AST_FLOW_WRITE: assert property (s_flow_write |-> wr_fire)
      else $error("flow-through write data not taken on second edge");

   AST_SLEEP_IN: assert property (sleep_request [*2] |=> sleep_active)
      else $error("sleep not entered two cycles after request");

   AST_SLEEP_OUT: assert property (!sleep_request [*2] |=> !sleep_active)
      else $error("sleep not left two cycles after release");

   AST_WRITE_OFF: assert property (wr_fire |-> !lane_io_oe)
      else $error("drivers on during write data cycle");

   AST_BURST_WRAP: assert property (run && !load && kind_reg != sram_core_pkg::KIND_IDLE
                                    |=> cnt_reg == $past(cnt_reg) + 2'h1)
      else $error("burst counter did not step");

endmodule : sync_burst_sram_core

`default_nettype wire

// ==== tb/host_ctrl_model.sv ====
// host controller model that drives late write data onto the data pins
// assumes commands come from the bench and are taken on ungated rising edges
`timescale 1ns/1ps
`default_nettype none

module host_ctrl_model (
   input  wire logic                      ref_clk,
   input  wire logic                      clock_gate_n,
   input  wire logic                      latency_select_n,
   input  wire logic                      wr_cmd,
   input  wire sram_core_pkg::data_word_t wr_data,
   output var  sram_core_pkg::data_word_t lane_io_in,
   output var  logic                      host_drive
);
   logic [1:0]                v_reg = 2'b00;
   sram_core_pkg::data_word_t d1_reg = '0;
   sram_core_pkg::data_word_t d2_reg = '0;
   sram_core_pkg::data_word_t last_reg = '0;

   // late write data, held on gated edges
   always_ff @(posedge ref_clk) begin
      if (!clock_gate_n) begin
         v_reg <= {v_reg[0], wr_cmd};
         d1_reg <= wr_data;
         d2_reg <= d1_reg;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (host_drive) begin
         last_reg <= lane_io_in;
      end
   end

   // drive only in write data cycles, else the inverse
   always_comb begin
      host_drive = latency_select_n ? v_reg[1] : v_reg[0];
      lane_io_in = host_drive ? (latency_select_n ? d2_reg : d1_reg) : ~last_reg;
   end
endmodule : host_ctrl_model

`default_nettype wire

// ==== tb/tb_sync_burst_sram_core.sv ====
// self-checking testbench of the burst sram core
// assumes the package, the core and the host model are compiled first
`timescale 1ns/1ps
`default_nettype none

module tb_sync_burst_sram_core;
   localparam logic [35:0] W1 = 36'h123456789;
   localparam logic [35:0] W2 = 36'hfedcba987;
   localparam logic [35:0] W3 = 36'h5a5a5a5a5;
   localparam logic [35:0] M  = 36'h007fc01ff;
   logic                      ref_clk = 1'b0;
   logic                      rst = 1'b1;
   logic                      clock_gate_n = 1'b0;
   logic                      burst_step_or_load = 1'b0;
   logic                      write_strobe_n = 1'b1;
   logic                      chip_select_first_n = 1'b1;
   logic                      chip_select_second = 1'b1;
   logic                      chip_select_third_n = 1'b0;
   logic [3:0]                lane_n = 4'hf;
   logic [16:0]               addr = 17'h00000;
   logic                      output_drive_n = 1'b0;
   logic                      latency_select_n = 1'b1;
   logic                      sequential_order_n = 1'b0;
   logic                      sleep_request = 1'b0;
   logic                      wr_cmd = 1'b0;
   sram_core_pkg::data_word_t wr_data = '0;
   sram_core_pkg::data_word_t lane_io_in;
   sram_core_pkg::data_word_t lane_io_out;
   logic                      lane_io_oe;
   logic                      sleep_active;
   logic                      host_drive;
   int                        desel = 3;
   int                        n_mismatch = 0;
   int                        n_compared = 0;

   sync_burst_sram_core sync_burst_sram_core_i (
      .ref_clk(ref_clk), .rst(rst), .clock_gate_n(clock_gate_n),
      .burst_step_or_load(burst_step_or_load), .write_strobe_n(write_strobe_n),
      .chip_select_first_n(chip_select_first_n), .chip_select_second(chip_select_second),
      .chip_select_third_n(chip_select_third_n), .lane_a_strobe_n(lane_n[0]),
      .lane_b_strobe_n(lane_n[1]), .lane_c_strobe_n(lane_n[2]), .lane_d_strobe_n(lane_n[3]),
      .addr_upper(addr[16:2]), .burst_start_bits(addr[1:0]),
      .output_drive_n(output_drive_n), .latency_select_n(latency_select_n),
      .sequential_order_n(sequential_order_n), .sleep_request(sleep_request),
      .lane_io_in(lane_io_in), .lane_io_out(lane_io_out), .lane_io_oe(lane_io_oe),
      .sleep_active(sleep_active));

   host_ctrl_model host_ctrl_model_i (
      .ref_clk(ref_clk), .clock_gate_n(clock_gate_n), .latency_select_n(latency_select_n),
      .wr_cmd(wr_cmd), .wr_data(wr_data), .lane_io_in(lane_io_in), .host_drive(host_drive));

   always #12.5 ref_clk = ~ref_clk;

   // no contention on the data pins
   always @(negedge ref_clk) begin
      if (!rst && host_drive === 1'b1 && lane_io_oe !== 1'b0) begin
         n_mismatch++;
         $display("BAD lane_io_oe in write data expected 0 seen %b", lane_io_oe);
      end
   end

   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : final_report

   task automatic chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // every new access loads with step low
   // kinds: 0 idle, 1 read, 2 write, 3 write step, 4 read step
   task automatic cmd(input int k, input logic [16:0] a, input logic [35:0] d,
                      input logic [3:0] ln);
      burst_step_or_load = (k >= 3);
      write_strobe_n = (k != 2);
      chip_select_first_n = (k == 0) || (desel == 0);
      chip_select_second = (desel != 1);
      chip_select_third_n = (desel == 2);
      addr = a;
      wr_data = d;
      lane_n = ln;
      // host drives data of accepted writes only
      wr_cmd = (k == 3) || (k == 2 && desel == 3);
      @(negedge ref_clk);
   endtask : cmd

   task automatic idle(input int n);
      repeat (n) cmd(0, 17'h00000, 36'h0, 4'hf);
   endtask : idle

   task automatic rd(input logic [16:0] a, input logic [35:0] exp);
      cmd(1, a, 36'h0, 4'hf);
      if (latency_select_n) begin
         chk("lane_io_oe early", 36'h0, {35'h0, lane_io_oe});
         idle(1);
      end
      chk("lane_io_oe", 36'h1, {35'h0, lane_io_oe});
      chk("lane_io_out", exp, lane_io_out);
      idle(1);
   endtask : rd

   task automatic t_pipe();
      cmd(2, 17'h00010, W1, 4'h0);
      cmd(2, 17'h00020, W2, 4'h0);
      idle(2);
      cmd(2, 17'h00010, W2, 4'b1010);
      rd(17'h00020, W2);
      rd(17'h00010, (W2 & M) | (W1 & ~M));
      cmd(2, 17'h00010, W3, 4'hf);
      idle(2);
      rd(17'h00010, (W2 & M) | (W1 & ~M));
      cmd(1, 17'h00020, 36'h0, 4'hf);
      cmd(2, 17'h00050, W1, 4'h0);
      chk("turn lane_io_oe", 36'h1, {35'h0, lane_io_oe});
      chk("turn lane_io_out", W2, lane_io_out);
      idle(2);
      rd(17'h00050, W1);
      $display("test pipe done");
   endtask : t_pipe

   task automatic t_flow();
      latency_select_n = 1'b0;
      cmd(2, 17'h00030, W3, 4'h0);
      idle(1);
      rd(17'h00030, W3);
      latency_select_n = 1'b1;
      rd(17'h00030, W3);
      $display("test flow done");
   endtask : t_flow

   task automatic t_burst();
      logic [1:0] p;
      for (int o = 0; o < 2; o++) begin
         sequential_order_n = o[0];
         cmd(2, 17'h00041, 36'h100, 4'h0);
         for (int k = 1; k < 5; k++) cmd(3, 17'h1ffff, 36'h100 + k, 4'h0);
         idle(2);
         for (int k = 1; k < 4; k++) begin
            p = o[0] ? (2'd1 ^ k[1:0]) : (2'd1 + k[1:0]);
            rd({15'h0010, p}, 36'h100 + k);
         end
         rd(17'h00041, 36'h104);
         cmd(1, 17'h00041, 36'h0, 4'hf);
         for (int k = 0; k < 4; k++) begin
            cmd((k < 3) ? 4 : 0, 17'h1ffff, 36'h0, 4'hf);
            chk("burst lane_io_out", (k == 0) ? 36'h104 : 36'h100 + k, lane_io_out);
         end
      end
      $display("test burst done");
   endtask : t_burst

   task automatic t_select();
      for (int i = 0; i < 3; i++) begin
         desel = i;
         cmd(2, 17'h00020, W3, 4'h0);
         desel = 3;
         idle(2);
         rd(17'h00020, W2);
      end
      $display("test select done");
   endtask : t_select

   task automatic t_gate();
      cmd(1, 17'h00020, 36'h0, 4'hf);
      idle(1);
      clock_gate_n = 1'b1;
      cmd(2, 17'h00020, W1, 4'h0);
      cmd(2, 17'h00020, W1, 4'h0);
      chk("gated lane_io_oe", 36'h1, {35'h0, lane_io_oe});
      chk("gated lane_io_out", W2, lane_io_out);
      clock_gate_n = 1'b0;
      idle(3);
      rd(17'h00020, W2);
      $display("test gate done");
   endtask : t_gate

   task automatic t_oe();
      cmd(1, 17'h00020, 36'h0, 4'hf);
      idle(1);
      output_drive_n = 1'b1;
      #1;
      chk("forced lane_io_oe", 36'h0, {35'h0, lane_io_oe});
      output_drive_n = 1'b0;
      #1;
      chk("released lane_io_oe", 36'h1, {35'h0, lane_io_oe});
      idle(1);
      $display("test drive enable done");
   endtask : t_oe

   task automatic t_sleep();
      sleep_request = 1'b1;
      @(negedge ref_clk);
      chk("sleep_active one edge", 36'h0, {35'h0, sleep_active});
      @(negedge ref_clk);
      chk("sleep_active two edges", 36'h1, {35'h0, sleep_active});
      sleep_request = 1'b0;
      @(negedge ref_clk);
      chk("wake one edge", 36'h1, {35'h0, sleep_active});
      @(negedge ref_clk);
      chk("wake two edges", 36'h0, {35'h0, sleep_active});
      rd(17'h00020, W2);
      $display("test sleep done");
   endtask : t_sleep

   initial begin
      repeat (5) @(negedge ref_clk);
      rst = 1'b0;
      t_pipe();
      t_flow();
      t_burst();
      t_select();
      t_gate();
      t_oe();
      t_sleep();
      final_report();
   end

   initial begin
      #(25 * 3000);
      n_mismatch++;
      $display("BAD watchdog expected done seen timeout");
      final_report();
   end
endmodule : tb_sync_burst_sram_core

`default_nettype wire
